// *** dual_serial_regs.svh ***
// Timing constants and frame layout for the dual serial ports
`ifndef DUAL_SERIAL_REGS_SVH
`define DUAL_SERIAL_REGS_SVH
`define CLK_HZ 50000000
`define BAUD_MIN 300
`define BAUD_MAX 256000
`define DIV_W 18
`define DIV_MIN (`CLK_HZ / `BAUD_MAX)
`define DIV_MAX (`CLK_HZ / `BAUD_MIN)
`define DIV_RESET 18'h01B2
`define DATA_BITS 8
`define START_LEVEL 1'b0
`define STOP_LEVEL 1'b1
`define IDLE_LEVEL 1'b1
`define BIT_IDX_LAST 3'h7
`endif

// *** dual_serial_pkg.sv ***
// Types shared by the dual serial port design
package dual_serial_pkg;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
   typedef struct packed {
      logic [7:0] data;
      logic frame_err;
   } rx_word_t;
   typedef struct packed {
      logic [1:0] count;
      rx_word_t [1:0] slot;
      logic rd_ptr;
   } buf_t;
   typedef struct packed {
      tx_state_t tx_state;
      logic [17:0] tx_cnt;
      logic [2:0] tx_bit;
      logic [7:0] tx_shift;
      logic tx_line;
      logic tx_ready;
      logic rx_s1;
      logic rx_s2;
      logic rx_prev;
      rx_state_t rx_state;
      logic [17:0] rx_cnt;
      logic [2:0] rx_bit;
      logic [7:0] rx_shift;
      buf_t rxb;
      logic out_valid;
      rx_word_t out_word;
      logic boot_owner;
      logic app_tx_ready;
      logic app_rx_valid;
      logic own_tx_ready;
      logic own_rx_valid;
   } port_state_t;
endpackage : dual_serial_pkg

// *** dual_async_serial_ports.sv ***
// Two independent full-duplex serial ports with buffered receive
`timescale 1ns/1ps
`include "dual_serial_regs.svh"
module dual_async_serial_ports #(
   parameter int PORTS = 2
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [17:0] baud_div_i [PORTS],
   input wire logic buffered_i [PORTS],
   input wire logic app_running_i,
   input wire logic tx_valid_i [PORTS],
   input wire logic [7:0] tx_data_i [PORTS],
   output logic tx_ready_o [PORTS],
   input wire logic boot_tx_valid_i,
   input wire logic [7:0] boot_tx_data_i,
   output logic boot_tx_ready_o,
   output logic boot_rx_valid_o,
   output logic [7:0] boot_rx_data_o,
   input wire logic rx_rd_i [PORTS],
   output logic rx_valid_o [PORTS],
   output logic [7:0] rx_data_o [PORTS],
   output logic rx_frame_err_o [PORTS],
   output logic serial_tx_o [PORTS],
   input wire logic serial_rx_i [PORTS]
);
   // Refuse port counts that the single download path cannot serve
   if (PORTS != 2) begin : gen_bad_ports
      $error("dual_async_serial_ports serves exactly two ports");
   end

   // Port zero hosts the download path; port one never does
   dual_serial_pkg::port_state_t st [PORTS];
   dual_serial_pkg::port_state_t next_st [PORTS];

   // One identical port per index; only index zero can belong to the download path
   genvar g;
   generate
      for (g = 0; g < PORTS; g++) begin : gen_port
         logic [17:0] div;
         logic is_boot;
         logic tx_v;
         logic [7:0] tx_d;
         logic in_ready;
         logic push;
         logic pop;
         logic do_push;
         dual_serial_pkg::rx_word_t push_word;
         // Clamp divisor into the supported baud range
         always_comb begin
            if (baud_div_i[g] < 18'(`DIV_MIN)) div = 18'(`DIV_MIN);
            else if (baud_div_i[g] > 18'(`DIV_MAX)) div = 18'(`DIV_MAX);
            else div = baud_div_i[g];
         end
         // Transmit source steered by ownership of port zero
         assign is_boot = (g == 0) && st[g].boot_owner;
         assign tx_v = is_boot ? boot_tx_valid_i : tx_valid_i[g];
         assign tx_d = is_boot ? boot_tx_data_i : tx_data_i[g];

         always_comb begin
            next_st[g] = st[g];
            push = 1'b0;
            push_word = '0;
            // Ownership moves to the application once it starts and stays there
            if (app_running_i) next_st[g].boot_owner = 1'b0;
            // Transmitter: start, 8 data LSB first, stop, idle high
            case (st[g].tx_state)
               dual_serial_pkg::TX_IDLE: begin
                  next_st[g].tx_line = `IDLE_LEVEL;
                  next_st[g].tx_ready = 1'b1;
                  if (tx_v && st[g].tx_ready) begin
                     next_st[g].tx_shift = tx_d;
                     next_st[g].tx_ready = 1'b0;
                     next_st[g].tx_cnt = div - 18'h00001;
                     next_st[g].tx_line = `START_LEVEL;
                     next_st[g].tx_state = dual_serial_pkg::TX_START;
                  end
               end
               default: begin
                  next_st[g].tx_ready = 1'b0;
                  if (st[g].tx_cnt != 18'h00000) begin
                     next_st[g].tx_cnt = st[g].tx_cnt - 18'h00001;
                  end else begin
                     next_st[g].tx_cnt = div - 18'h00001;
                     case (st[g].tx_state)
                        dual_serial_pkg::TX_START: begin
                           next_st[g].tx_line = st[g].tx_shift[0];
                           next_st[g].tx_bit = 3'h0;
                           next_st[g].tx_state = dual_serial_pkg::TX_DATA;
                        end
                        dual_serial_pkg::TX_DATA: begin
                           if (st[g].tx_bit == `BIT_IDX_LAST) begin
                              next_st[g].tx_line = `STOP_LEVEL;
                              next_st[g].tx_state = dual_serial_pkg::TX_STOP;
                           end else begin
                              next_st[g].tx_shift = {1'b0, st[g].tx_shift[7:1]};
                              next_st[g].tx_line = st[g].tx_shift[1];
                              next_st[g].tx_bit = st[g].tx_bit + 3'h1;
                           end
                        end
                        default: begin
                           next_st[g].tx_line = `IDLE_LEVEL;
                           next_st[g].tx_ready = 1'b1;
                           next_st[g].tx_state = dual_serial_pkg::TX_IDLE;
                        end
                     endcase
                  end
               end
            endcase

            // Two-stage synchroniser on the receive pin
            next_st[g].rx_s1 = serial_rx_i[g];
            next_st[g].rx_s2 = st[g].rx_s1;
            next_st[g].rx_prev = st[g].rx_s2;
            // Receiver: falling edge starts, samples at bit centres
            case (st[g].rx_state)
               dual_serial_pkg::RX_IDLE: begin
                  if (st[g].rx_prev && !st[g].rx_s2) begin
                     next_st[g].rx_cnt = {1'b0, div[17:1]};
                     next_st[g].rx_state = dual_serial_pkg::RX_START;
                  end
               end
               default: begin
                  if (st[g].rx_cnt != 18'h00000) begin
                     next_st[g].rx_cnt = st[g].rx_cnt - 18'h00001;
                  end else begin
                     next_st[g].rx_cnt = div - 18'h00001;
                     case (st[g].rx_state)
                        dual_serial_pkg::RX_START: begin
                           // A start bit that is high at centre was a glitch
                           next_st[g].rx_bit = 3'h0;
                           next_st[g].rx_state = st[g].rx_s2 ? dual_serial_pkg::RX_IDLE
                                                            : dual_serial_pkg::RX_DATA;
                        end
                        dual_serial_pkg::RX_DATA: begin
                           next_st[g].rx_shift = {st[g].rx_s2, st[g].rx_shift[7:1]};
                           next_st[g].rx_bit = st[g].rx_bit + 3'h1;
                           if (st[g].rx_bit == `BIT_IDX_LAST) begin
                              next_st[g].rx_state = dual_serial_pkg::RX_STOP;
                           end
                        end
                        default: begin
                           push = 1'b1;
                           push_word.data = st[g].rx_shift;
                           push_word.frame_err = (st[g].rx_s2 != `STOP_LEVEL);
                           next_st[g].rx_state = dual_serial_pkg::RX_IDLE;
                        end
                     endcase
                  end
               end
            endcase

            // Two-entry buffer: single-byte mode keeps one slot, buffered uses two
            in_ready = buffered_i[g] ? (st[g].rxb.count != 2'h2)
                                     : (st[g].rxb.count == 2'h0);
            begin
               pop = 1'b0;
               do_push = push && in_ready;
               if (!st[g].out_valid || (is_boot ? 1'b1 : rx_rd_i[g])) begin
                  if (st[g].rxb.count != 2'h0) begin
                     pop = 1'b1;
                     next_st[g].out_valid = 1'b1;
                     next_st[g].out_word = st[g].rxb.slot[st[g].rxb.rd_ptr];
                     next_st[g].rxb.rd_ptr = ~st[g].rxb.rd_ptr;
                  end else begin
                     next_st[g].out_valid = 1'b0;
                  end
               end
               if (do_push) begin
                  next_st[g].rxb.slot[st[g].rxb.rd_ptr ^ st[g].rxb.count[0]] = push_word;
               end
               next_st[g].rxb.count = st[g].rxb.count + {1'b0, do_push} - {1'b0, pop};
            end
            // Ownership-gated flags kept in flops so every output leaves a register
            next_st[g].app_tx_ready = next_st[g].tx_ready && !next_st[g].boot_owner;
            next_st[g].app_rx_valid = next_st[g].out_valid && !next_st[g].boot_owner;
            next_st[g].own_tx_ready = next_st[g].tx_ready && next_st[g].boot_owner;
            next_st[g].own_rx_valid = next_st[g].out_valid && next_st[g].boot_owner;
         end

         // Reset parks the line idle and hands port zero to the download logic

         always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               st[g] <= '0;
               st[g].tx_state <= dual_serial_pkg::TX_IDLE;
               st[g].rx_state <= dual_serial_pkg::RX_IDLE;
               st[g].tx_line <= `IDLE_LEVEL;
               st[g].rx_s1 <= 1'b1;
               st[g].rx_s2 <= 1'b1;
               st[g].rx_prev <= 1'b1;
               st[g].boot_owner <= (g == 0);
            end else begin
               st[g] <= next_st[g];
            end
         end

         // Outputs straight from state; port zero hidden from the app while booting
         assign serial_tx_o[g] = st[g].tx_line;
         assign tx_ready_o[g] = st[g].app_tx_ready;
         assign rx_valid_o[g] = st[g].app_rx_valid;
         assign rx_data_o[g] = st[g].out_word.data;
         assign rx_frame_err_o[g] = st[g].out_word.frame_err;
      end
   endgenerate

   // Download path views port zero only
   assign boot_tx_ready_o = st[0].own_tx_ready;
   assign boot_rx_valid_o = st[0].own_rx_valid;
   assign boot_rx_data_o = st[0].out_word.data;
endmodule : dual_async_serial_ports

// *** serial_ports_properties.sv ***
// Concurrent checks on the dual serial port boundary
`timescale 1ns/1ps
module serial_ports_checker #(
   parameter int PORTS = 2
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic app_running_i,
   input wire logic tx_valid_i [PORTS],
   input wire logic tx_ready_o [PORTS],
   input wire logic boot_tx_valid_i,
   input wire logic boot_tx_ready_o,
   input wire logic boot_rx_valid_o,
   input wire logic rx_rd_i [PORTS],
   input wire logic rx_valid_o [PORTS],
   input wire logic serial_tx_o [PORTS]
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Start bit held low for at least eight clocks
   sequence s_start;
      !serial_tx_o[1] [*8];
   endsequence
   // Line, ready and ownership relations
   property p_take; tx_valid_i[1] && tx_ready_o[1] |=> !tx_ready_o[1] throughout s_start; endproperty
   property p_idle; tx_ready_o[0] |-> serial_tx_o[0]; endproperty
   property p_boot_take; boot_tx_valid_i && boot_tx_ready_o |=> !serial_tx_o[0]; endproperty
   property p_own; boot_tx_ready_o |-> !tx_ready_o[0]; endproperty
   property p_pulse; boot_rx_valid_o |=> !boot_rx_valid_o; endproperty
   property p_handover; app_running_i ##1 app_running_i |-> !boot_tx_ready_o; endproperty
   property p_hold; rx_valid_o[1] && !rx_rd_i[1] |=> rx_valid_o[1]; endproperty
   property p_stop; $rose(tx_ready_o[1]) |-> serial_tx_o[1] && $past(serial_tx_o[1]); endproperty
   a_take: assert property (p_take) else $error("start bit missing");
   a_idle: assert property (p_idle) else $error("idle line low");
   a_boot_take: assert property (p_boot_take) else $error("boot send lost");
   a_own: assert property (p_own) else $error("port zero shared");
   a_pulse: assert property (p_pulse) else $error("boot pulse long");
   a_handover: assert property (p_handover) else $error("boot kept port");
   a_hold: assert property (p_hold) else $error("byte vanished");
   a_stop: assert property (p_stop) else $error("stop bit short");
endmodule : serial_ports_checker
bind dual_async_serial_ports serial_ports_checker #(.PORTS(PORTS)) i_chk (.clk_i(clk_i),
   .nrst_i(nrst_i), .app_running_i(app_running_i), .tx_valid_i(tx_valid_i),
   .tx_ready_o(tx_ready_o), .boot_tx_valid_i(boot_tx_valid_i), .rx_rd_i(rx_rd_i),
   .boot_tx_ready_o(boot_tx_ready_o), .boot_rx_valid_o(boot_rx_valid_o),
   .rx_valid_o(rx_valid_o), .serial_tx_o(serial_tx_o));

// *** serial_far_end.sv ***
// Far-end serial device model for one port
`timescale 1ns/1ps
module serial_far_end #(
   parameter int DIV = 195
) (
   input wire logic clk_i,
   input wire logic line_i,
   output logic line_o
);
   logic [7:0] got;
   initial line_o = 1'b1;
   // Sends start, data from bit 0 up, then the given stop level
   task automatic send(input logic [7:0] d, input logic stop);
      logic [9:0] fr;
      fr = {stop, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_o <= fr[i];
         repeat (DIV) @(posedge clk_i);
      end
      line_o <= 1'b1;
   endtask : send
   // Finds the start edge and samples each data bit at its centre
   always begin
      @(negedge line_i);
      repeat (DIV / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (DIV) @(posedge clk_i);
         got[i] = line_i;
      end
   end
endmodule : serial_far_end

// *** dual_async_serial_ports_test.sv ***
// Self-checking bench for the dual serial ports
`timescale 1ns/1ps
module dual_async_serial_ports_test;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [17:0] baud_div_i [2] = '{18'h000C3, 18'h00104};
   logic buffered_i [2] = '{1'b0, 1'b1};
   logic app_running_i = 1'b0;
   logic tx_valid_i [2] = '{1'b0, 1'b0};
   logic [7:0] tx_data_i [2] = '{8'h00, 8'h00};
   logic boot_tx_valid_i = 1'b0;
   logic [7:0] boot_tx_data_i = 8'h00;
   logic rx_rd_i [2] = '{1'b0, 1'b0};
   logic tx_ready_o [2];
   logic rx_valid_o [2];
   logic rx_frame_err_o [2];
   logic serial_tx_o [2];
   logic [7:0] rx_data_o [2];
   wire logic serial_rx_i [2];
   logic boot_tx_ready_o;
   logic boot_rx_valid_o;
   logic [7:0] boot_rx_data_o;
   int mismatches = 0;
   int n_checks = 0;
   wire logic [5:0] flag = {boot_tx_ready_o, tx_ready_o[1], tx_ready_o[0], boot_rx_valid_o,
      rx_valid_o[1], rx_valid_o[0]};
   always #10 clk_i = ~clk_i;
   dual_async_serial_ports i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .baud_div_i(baud_div_i),
      .buffered_i(buffered_i), .app_running_i(app_running_i), .tx_valid_i(tx_valid_i),
      .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o), .boot_tx_valid_i(boot_tx_valid_i),
      .boot_tx_data_i(boot_tx_data_i), .boot_tx_ready_o(boot_tx_ready_o),
      .boot_rx_valid_o(boot_rx_valid_o), .boot_rx_data_o(boot_rx_data_o), .rx_rd_i(rx_rd_i),
      .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_frame_err_o(rx_frame_err_o),
      .serial_tx_o(serial_tx_o), .serial_rx_i(serial_rx_i));
   serial_far_end #(.DIV(195)) i_far0 (.clk_i(clk_i), .line_i(serial_tx_o[0]),
      .line_o(serial_rx_i[0]));
   serial_far_end #(.DIV(260)) i_far1 (.clk_i(clk_i), .line_i(serial_tx_o[1]),
      .line_o(serial_rx_i[1]));
   task automatic report_and_stop();
      if (mismatches == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // Waits for one status flag under a cycle bound
   task automatic wait_flag(input int k);
      for (int i = 0; i < 6000; i++) begin
         @(posedge clk_i);
         if (flag[k] === 1'b1) return;
      end
      mismatches++;
      report_and_stop();
   endtask : wait_flag
   task automatic app_send(input int p, input logic [7:0] d);
      tx_valid_i[p] <= 1'b1;
      tx_data_i[p] <= d;
      wait_flag(3 + p);
      tx_valid_i[p] <= 1'b0;
      wait_flag(3 + p);
   endtask : app_send
   task automatic pop(input int p, input logic [7:0] d, input logic err);
      wait_flag(p);
      cmp(rx_data_o[p], d);
      cmp(8'(rx_frame_err_o[p]), 8'(err));
      rx_rd_i[p] <= 1'b1;
      @(posedge clk_i);
      rx_rd_i[p] <= 1'b0;
   endtask : pop
   task automatic t_reset();
      repeat (3) @(posedge clk_i);
      cmp(8'({serial_tx_o[1], serial_tx_o[0]}), 8'h03);
      cmp(8'({boot_tx_ready_o, tx_ready_o[0], tx_ready_o[1]}), 8'h05);
   endtask : t_reset
   task automatic t_boot();
      boot_tx_valid_i <= 1'b1;
      boot_tx_data_i <= 8'hA5;
      wait_flag(5);
      boot_tx_valid_i <= 1'b0;
      wait_flag(5);
      cmp(i_far0.got, 8'hA5);
      fork
         i_far0.send(8'h3C, 1'b1);
         begin
            wait_flag(2);
            cmp(boot_rx_data_o, 8'h3C);
         end
      join
      cmp(8'(rx_valid_o[0]), 8'h00);
   endtask : t_boot
   task automatic t_duplex();
      app_running_i <= 1'b1;
      @(posedge clk_i);
      fork
         app_send(0, 8'h81);
         app_send(1, 8'h7E);
         i_far0.send(8'h55, 1'b1);
         i_far1.send(8'hC3, 1'b1);
      join
      cmp(i_far0.got, 8'h81);
      cmp(i_far1.got, 8'h7E);
      pop(0, 8'h55, 1'b0);
      pop(1, 8'hC3, 1'b0);
   endtask : t_duplex
   // Overfills both receive paths; the shown byte plus the buffer depth survive
   task automatic t_buffer();
      i_far1.send(8'h11, 1'b1);
      i_far1.send(8'h22, 1'b1);
      i_far1.send(8'h33, 1'b1);
      i_far1.send(8'h99, 1'b1);
      i_far0.send(8'h44, 1'b1);
      i_far0.send(8'h66, 1'b1);
      i_far0.send(8'h77, 1'b1);
      pop(1, 8'h11, 1'b0);
      pop(1, 8'h22, 1'b0);
      pop(1, 8'h33, 1'b0);
      pop(0, 8'h44, 1'b0);
      pop(0, 8'h66, 1'b0);
      repeat (3) @(posedge clk_i);
      cmp(8'({rx_valid_o[1], rx_valid_o[0]}), 8'h00);
   endtask : t_buffer
   task automatic t_frame();
      i_far1.send(8'hA5, 1'b0);
      pop(1, 8'hA5, 1'b1);
      i_far1.send(8'h5A, 1'b1);
      pop(1, 8'h5A, 1'b0);
   endtask : t_frame
   // Mid-run reset held past 2 us; port zero returns to the download logic
   task automatic t_rearm();
      nrst_i <= 1'b0;
      app_running_i <= 1'b0;
      repeat (101) @(posedge clk_i);
      nrst_i <= 1'b1;
      t_reset();
   endtask : t_rearm
   // Reset, then the scenarios in order
   initial begin
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      t_reset();
      t_boot();
      t_duplex();
      t_buffer();
      t_frame();
      t_rearm();
      report_and_stop();
   end
endmodule : dual_async_serial_ports_test
